/* logic/ifeu_consts.svh */
// constants for the interrupt flag and enable unit
//
// Behaviour
// - global enable passes unmasked requests, else blocks
// - every reset clears global enable
// - return from interrupt sets global enable
// - taking clears enable, core pushes, vectors 0004h
// - external events reach vector in three-four cycles
// - clearing global enable defers, never drops, requests
// - pin edge per polarity bit sets pin flag
// - pin wakes sleep only if enabled before
// - after wake, vector only when global enable
// - timer FFh to 00h sets timer flag
// - masked port pin change sets port flag
// - change during port read may miss flag
// - control register bit order gie down to flags
// - first peripheral flags bits 6..0, matching enables
// - second peripheral flags bits 7..4, matching enables
// - hardware saves only return address on entry
`ifndef IFEU_CONSTS_SVH
`define IFEU_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define IFEU_OFS_CTRL     6'h00
`define IFEU_OFS_PFLAG1   6'h04
`define IFEU_OFS_PFLAG2   6'h08
`define IFEU_OFS_PEN1     6'h0c
`define IFEU_OFS_PEN2     6'h10
`define IFEU_OFS_OPTION   6'h14
`define IFEU_OFS_PAMASK   6'h18
`define IFEU_OFS_PBMASK   6'h1c
`define IFEU_OFS_ISTAT    6'h20
`define IFEU_OFS_IMASK    6'h24
`define IFEU_OFS_CORE     6'h28

// ----------------------------------------
// control, option and core register fields
// ----------------------------------------
`define IFEU_B_GIE        7
`define IFEU_B_PERIPHERAL_GROUP_ENABLE       6
`define IFEU_B_TIMER_OVERFLOW_ENABLE       5
`define IFEU_B_EXT_PIN_IRQ_ENABLE       4
`define IFEU_B_PORT_CHANGE_ENABLE      3
`define IFEU_B_TIMER_OVERFLOW_FLAG       2
`define IFEU_B_EXT_PIN_IRQ_FLAG       1
`define IFEU_B_PORT_CHANGE_FLAG      0
`define IFEU_B_EDGE       0
`define IFEU_B_SLEEP      0
`define IFEU_B_BUSY       1

// ----------------------------------------
// reset values, vector and timer wrap values
// ----------------------------------------
`define IFEU_RST_BYTE     8'h00
`define IFEU_VECTOR       13'h0004
`define IFEU_TMR_TOP      8'hff
`define IFEU_TMR_WRAP     8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define IFEU_TCY_NS       200
`define IFEU_MCLK_NS      50
`define IFEU_Q_CNT        ((`IFEU_TCY_NS + `IFEU_MCLK_NS - 1) / `IFEU_MCLK_NS)

`endif

/* logic/ifeu_pkg.sv */
// types for the interrupt flag and enable unit
package ifeu_pkg;

	// ----------------------------------------
	// interrupt taking sequence
	// ----------------------------------------
	typedef enum logic [1:0] {
		st_idle,
		st_arm,
		st_due
	} ifeu_take_t;

	typedef logic [7:0] ifeu_byte_t;

endpackage

/* logic/ifeu_top.sv */
// interrupt flag, enable, wake and vector logic with avalon register slave
`timescale 1ns/10ps
`include "ifeu_consts.svh"

module ifeu_top
	import ifeu_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// avalon-mm slave
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// pins
	input  wire logic        ext_irq_pin,
	input  wire logic [5:0]  port_a_pins,
	input  wire logic [3:0]  port_b_pins,
	// event sources
	input  wire logic [7:0]  eight_bit_timer_count,
	input  wire logic [6:0]  periph_evt_one,
	input  wire logic [3:0]  periph_evt_two,
	// core sequencer
	input  wire logic        return_from_irq,
	input  wire logic        core_sleep_enter,
	input  wire logic        core_port_read,
	output logic             core_vector,
	output logic [12:0]      core_vector_addr,
	output logic             core_wake,
	output logic             core_req,
	// system interrupt
	output logic             irq
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [1:0]  q_ff;
	logic        cyc_end;
	logic        wait_ff;
	logic [31:0] rdata_ff;
	logic        wr_go;
	logic        rd_go;
	ifeu_byte_t  wd;
	ifeu_byte_t  rd_mux;
	logic        gie_ff;
	logic        peripheral_group_enable_ff;
	logic        timer_overflow_enable_ff;
	logic        ext_pin_irq_enable_ff;
	logic        port_change_enable_ff;
	logic        timer_overflow_flag_ff;
	logic        ext_pin_irq_flag_ff;
	logic        port_change_flag_ff;
	logic [6:0]  peripheral_enable_one_ff;
	logic [3:0]  peripheral_enable_two_ff;
	logic [6:0]  peripheral_flag_one_ff;
	logic [3:0]  peripheral_flag_two_ff;
	logic        edge_sel_ff;
	logic [5:0]  port_a_change_mask_ff;
	logic [3:0]  port_b_change_mask_ff;
	logic [2:0]  istat_ff;
	logic [2:0]  imask_ff;
	logic [2:0]  ev_set;
	logic        irq_ff;
	logic        ext_s1_ff;
	logic        ext_s2_ff;
	logic        ext_prev_ff;
	logic [9:0]  pin_s1_ff;
	logic [9:0]  pin_s2_ff;
	logic [9:0]  port_latch_ff;
	logic [9:0]  chg;
	logic [9:0]  chg_mask;
	logic        edge_hit;
	logic [7:0]  tmr_prev_ff;
	logic        tmr_ovf;
	logic        periph_req;
	logic        local_req;
	logic        req_all;
	logic        sleep_ff;
	logic        sleep_ext_pin_irq_enable_ff;
	logic        wake_req;
	logic        wake_ff;
	logic        busy_ff;
	logic        take;
	logic        vec_ff;
	logic        req_ff;
	ifeu_take_t  take_st_ff;
	ifeu_take_t  nxt_take_st;
	logic        wr_ctrl;

	assign wd      = avs_writedata[7:0];
	assign wr_go   = avs_write & ~wait_ff & avs_byteenable[0];
	assign rd_go   = avs_read & ~wait_ff;
	assign wr_ctrl = wr_go && (avs_address == `IFEU_OFS_CTRL);

	// ----------------------------------------
	// instruction cycle phases
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q_ff <= 2'h0;
		end else if (cyc_end) begin
			q_ff <= 2'h0;
		end else begin
			q_ff <= q_ff + 2'h1;
		end
	end
	assign cyc_end = (q_ff == 2'(`IFEU_Q_CNT - 1));

	// ----------------------------------------
	// bus slave handshake
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wait_ff <= 1'b1;
		end else begin
			wait_ff <= ~((avs_read | avs_write) & wait_ff);
		end
	end

	always_comb begin
		rd_mux = 8'h00;
		case (avs_address)
			`IFEU_OFS_CTRL:   rd_mux = {gie_ff, peripheral_group_enable_ff, timer_overflow_enable_ff, ext_pin_irq_enable_ff,
			                            port_change_enable_ff, timer_overflow_flag_ff, ext_pin_irq_flag_ff, port_change_flag_ff};
			`IFEU_OFS_PFLAG1: rd_mux = {1'b0, peripheral_flag_one_ff};
			`IFEU_OFS_PFLAG2: rd_mux = {peripheral_flag_two_ff, 4'h0};
			`IFEU_OFS_PEN1:   rd_mux = {1'b0, peripheral_enable_one_ff};
			`IFEU_OFS_PEN2:   rd_mux = {peripheral_enable_two_ff, 4'h0};
			`IFEU_OFS_OPTION: rd_mux = {7'h00, edge_sel_ff};
			`IFEU_OFS_PAMASK: rd_mux = {2'h0, port_a_change_mask_ff};
			`IFEU_OFS_PBMASK: rd_mux = {port_b_change_mask_ff, 4'h0};
			`IFEU_OFS_ISTAT:  rd_mux = {5'h00, istat_ff};
			`IFEU_OFS_IMASK:  rd_mux = {5'h00, imask_ff};
			`IFEU_OFS_CORE:   rd_mux = {6'h00, busy_ff, sleep_ff};
			default:          rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata_ff <= 32'h0000_0000;
		end else if (avs_read & wait_ff) begin
			rdata_ff <= {24'h00_0000, rd_mux};
		end
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ext_s1_ff   <= 1'b0;
			ext_s2_ff   <= 1'b0;
			ext_prev_ff <= 1'b0;
			pin_s1_ff   <= 10'h000;
			pin_s2_ff   <= 10'h000;
		end else begin
			ext_s1_ff   <= ext_irq_pin;
			ext_s2_ff   <= ext_s1_ff;
			ext_prev_ff <= ext_s2_ff;
			pin_s1_ff   <= {port_b_pins, port_a_pins};
			pin_s2_ff   <= pin_s1_ff;
		end
	end

	// edge selection on the pin
	assign edge_hit = edge_sel_ff ? (ext_s2_ff & ~ext_prev_ff)
	                              : (~ext_s2_ff & ext_prev_ff);

	// ----------------------------------------
	// port change detect
	// ----------------------------------------
	assign chg_mask = {port_b_change_mask_ff, port_a_change_mask_ff};

	genvar gi;
	generate
		for (gi = 0; gi < 10; gi = gi + 1) begin : g_chg
			assign chg[gi] = chg_mask[gi] & (pin_s2_ff[gi] ^ port_latch_ff[gi]);
		end
	endgenerate

	// a port read refreshes the compare latch
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			port_latch_ff <= 10'h000;
		end else if (core_port_read) begin
			port_latch_ff <= pin_s2_ff;
		end
	end

	// ----------------------------------------
	// timer overflow detect
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tmr_prev_ff <= 8'h00;
		end else begin
			tmr_prev_ff <= eight_bit_timer_count;
		end
	end
	assign tmr_ovf = (tmr_prev_ff == `IFEU_TMR_TOP) &&
	                 (eight_bit_timer_count == `IFEU_TMR_WRAP);

	// ----------------------------------------
	// control register enables
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			gie_ff <= 1'b0;
		end else if (take) begin
			gie_ff <= 1'b0;
		end else if (return_from_irq) begin
			gie_ff <= 1'b1;
		end else if (wr_ctrl) begin
			gie_ff <= wd[`IFEU_B_GIE];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			peripheral_group_enable_ff  <= 1'b0;
			timer_overflow_enable_ff  <= 1'b0;
			ext_pin_irq_enable_ff  <= 1'b0;
			port_change_enable_ff <= 1'b0;
		end else if (wr_ctrl) begin
			peripheral_group_enable_ff  <= wd[`IFEU_B_PERIPHERAL_GROUP_ENABLE];
			timer_overflow_enable_ff  <= wd[`IFEU_B_TIMER_OVERFLOW_ENABLE];
			ext_pin_irq_enable_ff  <= wd[`IFEU_B_EXT_PIN_IRQ_ENABLE];
			port_change_enable_ff <= wd[`IFEU_B_PORT_CHANGE_ENABLE];
		end
	end

	// ----------------------------------------
	// control register flags, set wins
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			timer_overflow_flag_ff  <= 1'b0;
			ext_pin_irq_flag_ff  <= 1'b0;
			port_change_flag_ff <= 1'b0;
		end else begin
			timer_overflow_flag_ff  <= tmr_ovf | (wr_ctrl ? wd[`IFEU_B_TIMER_OVERFLOW_FLAG] : timer_overflow_flag_ff);
			ext_pin_irq_flag_ff  <= edge_hit | (wr_ctrl ? wd[`IFEU_B_EXT_PIN_IRQ_FLAG] : ext_pin_irq_flag_ff);
			port_change_flag_ff <= ((|chg) & ~core_port_read) |
			            (wr_ctrl ? wd[`IFEU_B_PORT_CHANGE_FLAG] : port_change_flag_ff);
		end
	end

	// ----------------------------------------
	// peripheral flags and enables, option, port masks and interrupt mask
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			peripheral_flag_one_ff <= 7'h00;
			peripheral_flag_two_ff <= 4'h0;
		end else begin
			peripheral_flag_one_ff <= periph_evt_one |
			           ((wr_go && avs_address == `IFEU_OFS_PFLAG1) ? wd[6:0] : peripheral_flag_one_ff);
			peripheral_flag_two_ff <= periph_evt_two |
			           ((wr_go && avs_address == `IFEU_OFS_PFLAG2) ? wd[7:4] : peripheral_flag_two_ff);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			peripheral_enable_one_ff     <= 7'h00;
			peripheral_enable_two_ff     <= 4'h0;
			edge_sel_ff <= 1'b1;
			port_a_change_mask_ff     <= 6'h00;
			port_b_change_mask_ff     <= 4'h0;
			imask_ff    <= 3'h0;
		end else if (wr_go) begin
			case (avs_address)
				`IFEU_OFS_PEN1:   peripheral_enable_one_ff     <= wd[6:0];
				`IFEU_OFS_PEN2:   peripheral_enable_two_ff     <= wd[7:4];
				`IFEU_OFS_OPTION: edge_sel_ff <= wd[`IFEU_B_EDGE];
				`IFEU_OFS_PAMASK: port_a_change_mask_ff     <= wd[5:0];
				`IFEU_OFS_PBMASK: port_b_change_mask_ff     <= wd[7:4];
				`IFEU_OFS_IMASK:  imask_ff    <= wd[2:0];
				default:          imask_ff    <= imask_ff;
			endcase
		end
	end

	// ----------------------------------------
	// request gating
	// ----------------------------------------
	assign periph_req = peripheral_group_enable_ff & ((|(peripheral_enable_one_ff & peripheral_flag_one_ff)) | (|(peripheral_enable_two_ff & peripheral_flag_two_ff)));
	assign local_req  = (timer_overflow_enable_ff & timer_overflow_flag_ff) | (ext_pin_irq_enable_ff & ext_pin_irq_flag_ff) | (port_change_enable_ff & port_change_flag_ff);
	assign req_all    = local_req | periph_req;

	// ----------------------------------------
	// sleep and wake
	// ----------------------------------------
	assign wake_req = sleep_ff & ((sleep_ext_pin_irq_enable_ff & ext_pin_irq_flag_ff) | (timer_overflow_enable_ff & timer_overflow_flag_ff) |
	                  (port_change_enable_ff & port_change_flag_ff) | periph_req);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sleep_ff      <= 1'b0;
			sleep_ext_pin_irq_enable_ff <= 1'b0;
			wake_ff       <= 1'b0;
		end else begin
			wake_ff <= wake_req;
			if (wake_req) begin
				sleep_ff <= 1'b0;
			end else if (core_sleep_enter) begin
				sleep_ff      <= 1'b1;
				sleep_ext_pin_irq_enable_ff <= ext_pin_irq_enable_ff;
			end
		end
	end

	// ----------------------------------------
	// interrupt taking sequence
	// ----------------------------------------
	// idle: sampled at cycle end; arm: core finishes current instruction;
	// due: dummy cycle, then vector if still enabled
	always_comb begin
		nxt_take_st = take_st_ff;
		take        = 1'b0;
		case (take_st_ff)
			st_idle: begin
				if (cyc_end && gie_ff && req_all && !sleep_ff) begin
					nxt_take_st = st_arm;
				end
			end
			st_arm: begin
				if (!gie_ff) begin
					nxt_take_st = st_idle;
				end else if (cyc_end) begin
					nxt_take_st = st_due;
				end
			end
			st_due: begin
				if (!gie_ff) begin
					nxt_take_st = st_idle;
				end else if (cyc_end) begin
					take        = req_all;
					nxt_take_st = st_idle;
				end
			end
			default: nxt_take_st = st_idle;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			take_st_ff <= st_idle;
		end else begin
			take_st_ff <= nxt_take_st;
		end
	end

	// core pushes only the return address on this pulse
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			vec_ff  <= 1'b0;
			req_ff  <= 1'b0;
			busy_ff <= 1'b0;
		end else begin
			vec_ff <= take;
			req_ff <= gie_ff & req_all;
			if (take) begin
				busy_ff <= 1'b1;
			end else if (return_from_irq) begin
				busy_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// system interrupt status
	// ----------------------------------------
	assign ev_set = {return_from_irq, wake_req, take};

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			istat_ff <= 3'h0;
			irq_ff   <= 1'b0;
		end else begin
			istat_ff <= ev_set |
			            ((rd_go && avs_address == `IFEU_OFS_ISTAT) ? 3'h0 : istat_ff);
			irq_ff   <= |(istat_ff & imask_ff);
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign avs_readdata     = rdata_ff;
	assign avs_waitrequest  = wait_ff;
	assign core_vector      = vec_ff;
	assign core_vector_addr = `IFEU_VECTOR;
	assign core_wake        = wake_ff;
	assign core_req         = req_ff;
	assign irq              = irq_ff;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_leave_arm;
		##[1:4] (take_st_ff != st_arm);
	endsequence

	sequence s_reach_due;
		(take_st_ff == st_arm) ##[1:4] (take_st_ff == st_due);
	endsequence

	vec_clears_gie_a: assert property (take |=> (!gie_ff && vec_ff))
		else $error("vector taken but global enable stayed set");
	vec_needs_gie_a: assert property (vec_ff |-> $past(gie_ff, 2))
		else $error("vector issued without global enable");
	ret_sets_gie_a: assert property ((return_from_irq && !take) |=> gie_ff)
		else $error("return did not set global enable");
	tmr_flag_a: assert property (tmr_ovf |=> timer_overflow_flag_ff)
		else $error("timer overflow flag missed");
	pin_edge_a: assert property (edge_hit |=> ext_pin_irq_flag_ff)
		else $error("pin edge flag missed");
	port_race_a: assert property ((core_port_read && !port_change_flag_ff && !wr_ctrl) |=> !port_change_flag_ff)
		else $error("port flag set during port read");
	port_chg_a: assert property (((|chg) && !core_port_read) |=> port_change_flag_ff)
		else $error("port change flag missed");
	arm_leave_a: assert property ($rose(take_st_ff == st_arm) |-> s_leave_arm)
		else $error("arm phase overran one instruction cycle");
	due_path_a: assert property ((take_st_ff == st_arm && cyc_end && gie_ff) |-> s_reach_due)
		else $error("due phase not reached");
	peripheral_group_enable_gate_a: assert property ((!peripheral_group_enable_ff && !local_req) |=> !req_ff)
		else $error("peripheral request passed without group enable");
	wake_sleep_a: assert property (core_wake |-> $past(sleep_ff))
		else $error("wake pulse while not asleep");
	gie_block_a: assert property (!gie_ff |=> !req_ff)
		else $error("request passed with global enable clear");

endmodule

/* test/ifeu_core_model.sv */
// core sequencer model facing the interrupt unit
`timescale 1ns/10ps

module ifeu_core_model
	import ifeu_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// from unit
	input  wire logic       core_vector,
	input  wire logic       core_wake,
	// bench commands
	input  wire logic       ret_go,
	input  wire logic       sleep_go,
	// to unit, and stack depth and wake count to bench
	output logic            return_from_irq,
	output logic            core_sleep_enter,
	output logic [3:0]      depth,
	output logic [7:0]      wake_cnt
);
	// ----------------------------------------
	// stack and sequencing
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			depth <= 4'h0;
		end else if (core_vector) begin
			depth <= depth + 4'h1;
		end else if (return_from_irq) begin
			depth <= depth - 4'h1;
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			return_from_irq <= 1'b0;
			core_sleep_enter <= 1'b0;
			wake_cnt <= 8'h00;
		end else begin
			return_from_irq <= ret_go && depth != 4'h0;
			core_sleep_enter <= sleep_go;
			wake_cnt <= wake_cnt + {7'h00, core_wake};
		end
	end
endmodule

/* test/test_interrupt_flag_enable_unit.sv */
// self-checking bench for the interrupt flag and enable unit
`timescale 1ns/10ps
`include "ifeu_consts.svh"

module test_interrupt_flag_enable_unit
	import ifeu_pkg::*;
;
	logic        mclk = 0, rst = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
	logic [5:0]  avs_address = 0, port_a_pins = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, rd;
	logic [3:0]  port_b_pins = 0, pe2 = 0, depth;
	logic [6:0]  pe1 = 0;
	logic [7:0]  wake_cnt;
	logic [12:0] cva;
	ifeu_byte_t  tmr = 8'h10;
	logic        pin = 0, cpr = 0, rfi, sle, cv, cw, creq, irq, ret_go = 0, sleep_go = 0;
	int          num_errors = 0, num_checks = 0, n;

	always #25 mclk = ~mclk;

	ifeu_top dut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_irq_pin(pin),
		.port_a_pins(port_a_pins), .port_b_pins(port_b_pins), .eight_bit_timer_count(tmr),
		.periph_evt_one(pe1), .periph_evt_two(pe2), .return_from_irq(rfi),
		.core_sleep_enter(sle), .core_port_read(cpr), .core_vector(cv),
		.core_vector_addr(cva), .core_wake(cw), .core_req(creq), .irq(irq));

	ifeu_core_model core (.mclk(mclk), .rst(rst), .core_vector(cv), .core_wake(cw),
		.ret_go(ret_go), .sleep_go(sleep_go), .return_from_irq(rfi),
		.core_sleep_enter(sle), .depth(depth), .wake_cnt(wake_cnt));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task end_sim;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task tick(input int k);
		repeat (k) @(posedge mclk);
	endtask
	task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 20) begin
			chk(32'h1, 32'h0);
			end_sim;
		end
	endtask
	task wr(input logic [5:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task rchk(input logic [5:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(rd, {24'h0, e});
	endtask
	task wait_on(input logic wake, input int lim);
		n = 0;
		while ((wake ? cw : cv) !== 1'b1 && n < lim) begin
			@(posedge mclk);
			n++;
		end
		if (n >= lim) begin
			chk(32'h0, 32'h1);
			end_sim;
		end
	endtask
	task cmd(input logic s);
		@(posedge mclk);
		if (s) sleep_go <= 1'b1;
		else ret_go <= 1'b1;
		@(posedge mclk);
		sleep_go <= 1'b0;
		ret_go <= 1'b0;
	endtask
	task drive_pin(input logic v);
		@(posedge mclk);
		pin <= v;
		tick(5);
	endtask
	task pread;
		@(posedge mclk);
		cpr <= 1'b1;
		@(posedge mclk);
		cpr <= 1'b0;
	endtask
	task timer_wrap;
		@(posedge mclk);
		tmr <= 8'hff;
		@(posedge mclk);
		tmr <= 8'h00;
		tick(3);
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		end_sim;
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		tick(3);
		rst <= 1'b0;
		rchk(`IFEU_OFS_CTRL, 8'h00);
		rchk(`IFEU_OFS_OPTION, 8'h01);
		rchk(`IFEU_OFS_PFLAG1, 8'h00);
		rchk(`IFEU_OFS_PEN2, 8'h00);
		rchk(6'h3c, 8'h00);
		wr(`IFEU_OFS_PEN1, 8'hff);
		rchk(`IFEU_OFS_PEN1, 8'h7f);
		wr(`IFEU_OFS_PEN2, 8'hff);
		rchk(`IFEU_OFS_PEN2, 8'hf0);
		wr(`IFEU_OFS_PEN1, 8'h00);
		wr(`IFEU_OFS_PEN2, 8'h00);
		for (int i = 0; i < 7; i++) begin
			@(posedge mclk);
			pe1 <= 7'h1 << i;
			@(posedge mclk);
			pe1 <= 7'h0;
			rchk(`IFEU_OFS_PFLAG1, 8'h1 << i);
			wr(`IFEU_OFS_PFLAG1, 8'h00);
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			pe2 <= 4'h1 << i;
			@(posedge mclk);
			pe2 <= 4'h0;
			rchk(`IFEU_OFS_PFLAG2, 8'h10 << i);
			wr(`IFEU_OFS_PFLAG2, 8'h00);
		end
		// pin edges under both polarities
		drive_pin(1'b1);
		rchk(`IFEU_OFS_CTRL, 8'h02);
		wr(`IFEU_OFS_CTRL, 8'h00);
		drive_pin(1'b0);
		rchk(`IFEU_OFS_CTRL, 8'h00);
		wr(`IFEU_OFS_OPTION, 8'h00);
		drive_pin(1'b1);
		rchk(`IFEU_OFS_CTRL, 8'h00);
		drive_pin(1'b0);
		rchk(`IFEU_OFS_CTRL, 8'h02);
		wr(`IFEU_OFS_CTRL, 8'h00);
		wr(`IFEU_OFS_OPTION, 8'h01);
		// timer: no flag short of the wrap
		@(posedge mclk);
		tmr <= 8'hfe;
		tick(3);
		rchk(`IFEU_OFS_CTRL, 8'h00);
		timer_wrap();
		rchk(`IFEU_OFS_CTRL, 8'h04);
		wr(`IFEU_OFS_CTRL, 8'h00);
		// port change through the masks
		wr(`IFEU_OFS_PAMASK, 8'h01);
		port_a_pins <= 6'h02;
		tick(5);
		rchk(`IFEU_OFS_CTRL, 8'h00);
		port_a_pins <= 6'h03;
		tick(5);
		rchk(`IFEU_OFS_CTRL, 8'h01);
		pread();
		wr(`IFEU_OFS_CTRL, 8'h00);
		wr(`IFEU_OFS_PBMASK, 8'h80);
		port_b_pins <= 4'h8;
		tick(5);
		rchk(`IFEU_OFS_CTRL, 8'h01);
		pread();
		wr(`IFEU_OFS_CTRL, 8'h00);
		// taken pin interrupt and return
		wr(`IFEU_OFS_IMASK, 8'h01);
		wr(`IFEU_OFS_CTRL, 8'h90);
		@(posedge mclk);
		pin <= 1'b1;
		wait_on(1'b0, 40);
		chk({31'h0, n >= 8 && n <= 17}, 32'h1);
		chk({19'h0, cva}, 32'h4);
		tick(2);
		chk({31'h0, irq}, 32'h1);
		rchk(`IFEU_OFS_CTRL, 8'h12);
		chk({28'h0, depth}, 32'h1);
		rchk(`IFEU_OFS_CORE, 8'h02);
		rchk(`IFEU_OFS_ISTAT, 8'h01);
		tick(2);
		chk({31'h0, irq}, 32'h0);
		wr(`IFEU_OFS_CTRL, 8'h10);
		cmd(1'b0);
		tick(3);
		rchk(`IFEU_OFS_CTRL, 8'h90);
		chk({28'h0, depth}, 32'h0);
		rchk(`IFEU_OFS_ISTAT, 8'h04);
		// timer request held back while global enable is off
		wr(`IFEU_OFS_CTRL, 8'h20);
		timer_wrap();
		tick(20);
		chk({28'h0, depth}, 32'h0);
		chk({31'h0, creq}, 32'h0);
		wr(`IFEU_OFS_CTRL, 8'ha4);
		wait_on(1'b0, 40);
		wr(`IFEU_OFS_CTRL, 8'h20);
		cmd(1'b0);
		// peripheral source needs the group enable
		wr(`IFEU_OFS_PEN1, 8'h01);
		@(posedge mclk);
		pe1 <= 7'h01;
		@(posedge mclk);
		pe1 <= 7'h00;
		tick(20);
		chk({28'h0, depth}, 32'h0);
		wr(`IFEU_OFS_CTRL, 8'he0);
		wait_on(1'b0, 40);
		wr(`IFEU_OFS_PFLAG1, 8'h00);
		wr(`IFEU_OFS_CTRL, 8'h60);
		cmd(1'b0);
		wr(`IFEU_OFS_PEN1, 8'h00);
		// sleep: wake without vector, then no wake when pin disabled
		drive_pin(1'b0);
		wr(`IFEU_OFS_CTRL, 8'h10);
		cmd(1'b1);
		@(posedge mclk);
		pin <= 1'b1;
		wait_on(1'b1, 40);
		tick(30);
		chk({28'h0, depth}, 32'h0);
		wr(`IFEU_OFS_CTRL, 8'h00);
		drive_pin(1'b0);
		cmd(1'b1);
		drive_pin(1'b1);
		wr(`IFEU_OFS_CTRL, 8'h10);
		drive_pin(1'b0);
		drive_pin(1'b1);
		tick(20);
		chk({24'h0, wake_cnt}, 32'h1);
		drive_pin(1'b0);
		// second reset mid-run, then wake with vector
		@(posedge mclk);
		rst <= 1'b1;
		tick(3);
		rst <= 1'b0;
		rchk(`IFEU_OFS_CTRL, 8'h00);
		wr(`IFEU_OFS_CTRL, 8'h90);
		cmd(1'b1);
		@(posedge mclk);
		pin <= 1'b1;
		wait_on(1'b1, 40);
		wait_on(1'b0, 60);
		end_sim;
	end
endmodule
